// file: src/csc_pkg.sv
// clock switch controller: shared constants, types and helpers
package csc_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADR_NEW_SEL = 8'h00;
   localparam logic [7:0] ADR_CUR_STAT = 8'h04;
   localparam logic [7:0] ADR_SW_CTRL = 8'h08;
   localparam logic [7:0] ADR_HF_FRQ = 8'h0c;
   localparam logic [7:0] ADR_OSC_STAT = 8'h10;
   localparam logic [7:0] ADR_HF_TUNE = 8'h14;
   localparam logic [7:0] ADR_OSC_EN = 8'h18;
   localparam logic [7:0] ADR_EVENT = 8'h1c;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int SRC_LSB = 4;
   localparam int SRC_W = 3;
   localparam int DIV_W = 4;
   localparam int CTRL_HOLD_BIT = 7;
   localparam int CTRL_SECPWR_BIT = 6;
   localparam int CTRL_DONE_BIT = 4;
   localparam int CTRL_PEND_BIT = 3;
   localparam int STAT_RDY_LSB = 2;
   localparam int STAT_PLL_BIT = 0;
   localparam int EVT_SWITCH_BIT = 0;
   localparam int EVT_FAIL_BIT = 1;
   localparam int HF_FRQ_W = 3;
   localparam int HF_TUNE_W = 6;
   localparam int NUM_OSC = 6;
   // oscillator vector bits, same order as the ready register
   localparam int OSC_EXT = 5;
   localparam int OSC_HF = 4;
   localparam int OSC_MF = 3;
   localparam int OSC_LF = 2;
   localparam int OSC_SEC = 1;
   localparam int OSC_ADC = 0;
   // ---------------------------------------------------------------
   // source selector codes
   // ---------------------------------------------------------------
   localparam logic [2:0] SRC_HF = 3'h0;
   localparam logic [2:0] SRC_HF_PLL = 3'h1;
   localparam logic [2:0] SRC_EXT_PLL = 3'h2;
   localparam logic [2:0] SRC_SEC = 3'h3;
   localparam logic [2:0] SRC_LF = 3'h4;
   localparam logic [2:0] SRC_MF = 3'h5;
   localparam logic [2:0] SRC_ADC = 3'h6;
   localparam logic [2:0] SRC_EXT = 3'h7;
   // ---------------------------------------------------------------
   // reset values and timing
   // ---------------------------------------------------------------
   localparam logic [2:0] RST_SRC = SRC_HF;
   localparam logic [3:0] RST_DIV = 4'h0;
   localparam logic [2:0] RST_HF_FRQ = 3'h0;
   localparam logic [5:0] RST_HF_TUNE = 6'h00;
   localparam logic [5:0] RST_OSC_EN = 6'h00;
   localparam int CLK_MHZ = 125;
   localparam int LOCK_TIMEOUT_US = 200;
   // longest wait in clock cycles: exact product, no rounding
   localparam int LOCK_TIMEOUT_CYC = LOCK_TIMEOUT_US * CLK_MHZ;

   typedef enum logic [1:0] {CSC_IDLE, CSC_WAIT, CSC_PLL_SWAP, CSC_SLEEP} csc_state_t;

   function automatic logic csc_is_pll(input logic [2:0] src);
      return (src == SRC_HF_PLL) || (src == SRC_EXT_PLL);
   endfunction : csc_is_pll

   // oscillator a source needs running; a pll source needs its input
   function automatic logic [5:0] csc_src_osc(input logic [2:0] src);
      logic [5:0] v;
      v = 6'h00;
      case (src)
         SRC_HF, SRC_HF_PLL: v[OSC_HF] = 1'b1;
         SRC_EXT, SRC_EXT_PLL: v[OSC_EXT] = 1'b1;
         SRC_SEC: v[OSC_SEC] = 1'b1;
         SRC_LF: v[OSC_LF] = 1'b1;
         SRC_MF: v[OSC_MF] = 1'b1;
         default: v[OSC_ADC] = 1'b1;
      endcase
      return v;
   endfunction : csc_src_osc
endpackage : csc_pkg

// file: src/csc_lock_timer.sv
// clock switch controller: pll lock timeout counter
`timescale 1ns/1ns
module csc_lock_timer #(
   parameter int CYCLES = csc_pkg::LOCK_TIMEOUT_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   output logic expired_o
);
   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
   } csc_timer_state_t;

   csc_timer_state_t q;
   csc_timer_state_t d;

   // ---------------------------------------------------------------
   // counting
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      if (!run_i) begin
         d.cnt = '0;
      end else if (!expired_o) begin
         d.cnt = q.cnt + CW'(1);
      end
   end

   // high from when the wait runs out, held there until run_i drops
   assign expired_o = run_i && (q.cnt == CW'(CYCLES - 1));

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : csc_lock_timer

// file: src/csc_wb_slave.sv
// clock switch controller: classic wishbone slave front end
`timescale 1ns/1ns
module csc_wb_slave (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] rdata_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wr_o
);
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } csc_wb_state_t;

   csc_wb_state_t q;
   csc_wb_state_t d;
   logic req;

   // ---------------------------------------------------------------
   // ack one cycle after the request, dropped the cycle after
   // ---------------------------------------------------------------
   always_comb begin
      req = wb_cyc_i && wb_stb_i && !q.ack;
      d = q;
      d.ack = req;
      if (req && !wb_we_i) begin
         d.dat = {24'h000000, rdata_i};
      end
   end

   // write lands on the edge the master sees ack; lane 0 carries data
   assign wr_o = wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0];
   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : csc_wb_slave

// file: src/csc_top.sv
// clock switch controller: registers, switch sequencer and pll input control
// Function
// [RL1] divider-only change is handled as a full switch, finishing fast.
// [RL2] no pending switch completes while the hold bit is one; a pll swap already in relock still completes on lock, whatever the hold bit.
// [RL3] current source/divider show old values until switch; then update, set done.
// [RL4] hardware clears pending when the switch completes.
// [RL5] pll input follows new selection, then held by current selection.
// [RL6] pll to pll input change: run on old, then suspend during relock.
// [RL7] pll failing to lock during a switch signals the fail-safe monitor; the code signals it only when a pll swap relock times out.
// [RL8] sleep before completion abandons the switch and sleeps; a pll swap in relock ignores sleep until it completes or times out.
// [RL9] wake with hold zero: run on new clock, set switch flag.
// [RL10] wake with hold one: stay on old clock, request again.
// [RL11] ready register bits 7..2 show usable oscillators, one each.
// [RL12] pll ready bit 0 needs pll enabled, input ready and locked.
// [RL13] writing a differing selection starts a switch and sets pending.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
module csc_top #(
   parameter int LOCK_CYCLES = csc_pkg::LOCK_TIMEOUT_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [5:0] osc_ready_i,
   output logic [5:0] osc_en_o,
   input wire logic pll_lock_i,
   output logic pll_en_o,
   output logic pll_from_ext_o,
   input wire logic sleep_i,
   output logic [2:0] clk_source_o,
   output logic [3:0] clk_divider_o,
   output logic clk_suspend_o,
   output logic fail_safe_monitor_fail_o,
   output logic clock_switch_irq_flag_o,
   output logic sec_osc_power_o,
   output logic [2:0] hf_freq_o,
   output logic [5:0] hf_tune_o
);
   typedef struct packed {
      csc_pkg::csc_state_t st;
      logic [2:0] new_src;
      logic [3:0] new_div;
      logic [2:0] cur_src;
      logic [3:0] cur_div;
      logic hold;
      logic sec_pwr;
      logic done;
      logic pending;
      logic [2:0] hf_frq;
      logic [5:0] hf_tune;
      logic [5:0] man_en;
      logic irq_flag;
      logic fail_flag;
      logic fail_pulse;
      logic pll_ext;
      logic lock_lost;
   } csc_top_state_t;

   csc_top_state_t q;
   csc_top_state_t d;
   logic wr;
   logic wr_new;
   logic expired;
   logic [7:0] rdata;
   logic new_pll;
   logic cur_pll;
   logic pll_swap;
   logic pll_in_rdy;
   logic pll_ready;
   logic new_ready;
   logic [5:0] osc_usable;
   logic complete;

   // ---------------------------------------------------------------
   // bus front end and lock timer
   // ---------------------------------------------------------------
   csc_wb_slave u_wb (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i),
      .rdata_i(rdata),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .wr_o(wr)
   );

   csc_lock_timer #(
      .CYCLES(LOCK_CYCLES)
   ) u_lock (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .run_i(q.st == csc_pkg::CSC_PLL_SWAP),
      .expired_o(expired)
   );

   assign wr_new = wr && (wb_adr_i == csc_pkg::ADR_NEW_SEL);

   // ---------------------------------------------------------------
   // oscillator and pll readiness
   // ---------------------------------------------------------------
   assign osc_en_o = q.man_en | csc_pkg::csc_src_osc(q.cur_src)
      | (q.pending ? csc_pkg::csc_src_osc(q.new_src) : 6'h00);
   // [RL11] usable = enabled and ready
   assign osc_usable = osc_ready_i & osc_en_o;
   assign new_pll = csc_pkg::csc_is_pll(q.new_src);
   assign cur_pll = csc_pkg::csc_is_pll(q.cur_src);
   // [RL6] two pll sources with different inputs
   assign pll_swap = new_pll && cur_pll && (q.new_src != q.cur_src);
   assign pll_en_o = cur_pll || (q.pending && new_pll);
   assign pll_in_rdy = q.pll_ext ? osc_usable[csc_pkg::OSC_EXT] : osc_usable[csc_pkg::OSC_HF];
   // [RL12] pll ready bit
   assign pll_ready = pll_en_o && pll_in_rdy && pll_lock_i;
   // for a pll swap only the new input must be up; the relock comes after
   assign new_ready = (new_pll && !pll_swap) ? pll_ready
      : |(osc_usable & csc_pkg::csc_src_osc(q.new_src));

   // ---------------------------------------------------------------
   // register read mux
   // ---------------------------------------------------------------
   always_comb begin
      rdata = 8'h00;
      if (wb_adr_i == csc_pkg::ADR_NEW_SEL) begin
         rdata = {1'b0, q.new_src, q.new_div};
      end else if (wb_adr_i == csc_pkg::ADR_CUR_STAT) begin
         rdata = {1'b0, q.cur_src, q.cur_div};
      end else if (wb_adr_i == csc_pkg::ADR_SW_CTRL) begin
         rdata[csc_pkg::CTRL_HOLD_BIT] = q.hold;
         rdata[csc_pkg::CTRL_SECPWR_BIT] = q.sec_pwr;
         rdata[csc_pkg::CTRL_DONE_BIT] = q.done;
         rdata[csc_pkg::CTRL_PEND_BIT] = q.pending;
      end else if (wb_adr_i == csc_pkg::ADR_HF_FRQ) begin
         rdata = {5'h00, q.hf_frq};
      end else if (wb_adr_i == csc_pkg::ADR_OSC_STAT) begin
         rdata = {osc_usable, 1'b0, pll_ready};
      end else if (wb_adr_i == csc_pkg::ADR_HF_TUNE) begin
         rdata = {2'h0, q.hf_tune};
      end else if (wb_adr_i == csc_pkg::ADR_OSC_EN) begin
         rdata = {q.man_en, 2'h0};
      end else if (wb_adr_i == csc_pkg::ADR_EVENT) begin
         rdata[csc_pkg::EVT_SWITCH_BIT] = q.irq_flag;
         rdata[csc_pkg::EVT_FAIL_BIT] = q.fail_flag;
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      complete = 1'b0;
      d.fail_pulse = 1'b0;
      // software writes first, so hardware sets below win over clears; the new selection write is applied last
      if (wr) begin
         if (wb_adr_i == csc_pkg::ADR_SW_CTRL) begin
            d.hold = wb_dat_i[csc_pkg::CTRL_HOLD_BIT];
            d.sec_pwr = wb_dat_i[csc_pkg::CTRL_SECPWR_BIT];
         end else if (wb_adr_i == csc_pkg::ADR_HF_FRQ) begin
            d.hf_frq = wb_dat_i[csc_pkg::HF_FRQ_W-1:0];
         end else if (wb_adr_i == csc_pkg::ADR_HF_TUNE) begin
            d.hf_tune = wb_dat_i[csc_pkg::HF_TUNE_W-1:0];
         end else if (wb_adr_i == csc_pkg::ADR_OSC_EN) begin
            d.man_en = wb_dat_i[7:csc_pkg::STAT_RDY_LSB];
         end else if (wb_adr_i == csc_pkg::ADR_EVENT) begin
            if (wb_dat_i[csc_pkg::EVT_SWITCH_BIT]) begin
               d.irq_flag = 1'b0;
            end
            if (wb_dat_i[csc_pkg::EVT_FAIL_BIT]) begin
               d.fail_flag = 1'b0;
            end
         end
      end
      case (q.st)
         csc_pkg::CSC_IDLE: begin
            if (sleep_i) begin
               d.st = csc_pkg::CSC_SLEEP;
            end else if (q.pending) begin
               d.st = csc_pkg::CSC_WAIT;
            end
         end
         csc_pkg::CSC_WAIT: begin
            // [RL8] sleep abandons the switch
            if (sleep_i) begin
               d.st = csc_pkg::CSC_SLEEP;
            end else if (!q.pending) begin
               d.st = csc_pkg::CSC_IDLE;
            // [RL2] hold keeps completion off
            end else if (!q.hold && new_ready) begin
               // [RL6] suspend only for the relock
               if (pll_swap) begin
                  d.st = csc_pkg::CSC_PLL_SWAP;
                  d.lock_lost = 1'b0;
               end else begin
                  // [RL1] divider-only change takes this same path
                  complete = 1'b1;
               end
            end
         end
         csc_pkg::CSC_PLL_SWAP: begin
            if (!pll_lock_i) begin
               d.lock_lost = 1'b1;
            end
            if (q.lock_lost && pll_lock_i) begin
               complete = 1'b1;
            // [RL7] no lock in time: tell the monitor, keep old clock
            end else if (expired) begin
               d.fail_pulse = 1'b1;
               d.fail_flag = 1'b1;
               d.pending = 1'b0;
               d.st = csc_pkg::CSC_IDLE;
            end
         end
         default: begin
            if (!sleep_i) begin
               // [RL9] wake onto the new clock
               if (q.pending && !q.hold) begin
                  complete = 1'b1;
               // [RL10] wake on old clock, request again
               end else if (q.pending) begin
                  d.st = csc_pkg::CSC_WAIT;
               end else begin
                  d.st = csc_pkg::CSC_IDLE;
               end
            end
         end
      endcase
      // [RL3] status moves only here
      if (complete) begin
         d.cur_src = q.new_src;
         d.cur_div = q.new_div;
         d.done = 1'b1;
         // [RL4] switch finished
         d.pending = 1'b0;
         d.irq_flag = 1'b1;
         d.st = csc_pkg::CSC_IDLE;
      end
      // [RL13] a differing selection raises pending
      if (wr_new) begin
         d.new_src = wb_dat_i[csc_pkg::SRC_LSB +: csc_pkg::SRC_W];
         d.new_div = wb_dat_i[csc_pkg::DIV_W-1:0];
         d.pending = {d.new_src, d.new_div} != {d.cur_src, d.cur_div};
         if (d.pending) begin
            d.done = 1'b0;
         end
      end
      // [RL5] pll input fixed by new selection, then by current
      if ((d.st == csc_pkg::CSC_PLL_SWAP) || (d.pending && !csc_pkg::csc_is_pll(d.cur_src)
            && csc_pkg::csc_is_pll(d.new_src) && (d.st != csc_pkg::CSC_SLEEP))) begin
         d.pll_ext = d.new_src == csc_pkg::SRC_EXT_PLL;
      end else begin
         d.pll_ext = d.cur_src == csc_pkg::SRC_EXT_PLL;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= csc_pkg::CSC_IDLE;
         q.new_src <= csc_pkg::RST_SRC;
         q.new_div <= csc_pkg::RST_DIV;
         q.cur_src <= csc_pkg::RST_SRC;
         q.cur_div <= csc_pkg::RST_DIV;
         q.hf_frq <= csc_pkg::RST_HF_FRQ;
         q.hf_tune <= csc_pkg::RST_HF_TUNE;
         q.man_en <= csc_pkg::RST_OSC_EN;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign clk_source_o = q.cur_src;
   assign clk_divider_o = q.cur_div;
   assign clk_suspend_o = q.st == csc_pkg::CSC_PLL_SWAP;
   assign fail_safe_monitor_fail_o = q.fail_pulse;
   assign clock_switch_irq_flag_o = q.irq_flag;
   assign sec_osc_power_o = q.sec_pwr;
   assign hf_freq_o = q.hf_frq;
   assign hf_tune_o = q.hf_tune;
   assign pll_from_ext_o = q.pll_ext;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   AST_DIV_ONLY: assert property ( // [RL1]
      (q.st == csc_pkg::CSC_WAIT) && q.pending && !q.hold && !sleep_i && !wr
      && (q.new_src == q.cur_src) && !new_pll && new_ready
      |=> (q.cur_div == $past(q.new_div)) && q.done)
      else $error("divider-only switch did not complete");
   AST_HOLD_BLOCKS: assert property ( // [RL2]
      q.hold && (q.st == csc_pkg::CSC_WAIT) && !sleep_i |=> $stable({q.cur_src, q.cur_div}))
      else $error("switch completed while held");
   AST_STATUS_DONE: assert property ( // [RL3]
      !$stable({q.cur_src, q.cur_div}) |-> q.done && q.irq_flag)
      else $error("status changed without done flag");
   AST_PEND_CLEAR: assert property ( // [RL4]
      !$stable({q.cur_src, q.cur_div}) && !$past(wr_new) |-> !q.pending)
      else $error("pending still set after switch");
   AST_PLL_INPUT: assert property ( // [RL5]
      (q.st == csc_pkg::CSC_PLL_SWAP) && ($past(q.st) == csc_pkg::CSC_PLL_SWAP)
      |-> pll_from_ext_o == (q.new_src == csc_pkg::SRC_EXT_PLL))
      else $error("pll input not following new selection");
   AST_SUSPEND: assert property ( // [RL6]
      (q.st == csc_pkg::CSC_WAIT) && pll_swap && !new_ready && !sleep_i
      |=> !clk_suspend_o ##1 $stable(q.cur_src))
      else $error("suspended before new input ready");
   AST_FAIL: assert property ( // [RL7]
      fail_safe_monitor_fail_o |-> $past(q.st) == csc_pkg::CSC_PLL_SWAP
      && (q.st == csc_pkg::CSC_IDLE) && q.fail_flag && $stable(q.cur_src))
      else $error("fail pulse outside a pll swap");
   AST_SLEEP_ABANDON: assert property ( // [RL8]
      sleep_i && (q.st == csc_pkg::CSC_WAIT)
      |=> (q.st == csc_pkg::CSC_SLEEP) && $stable({q.cur_src, q.cur_div}))
      else $error("switch not abandoned on sleep");
   AST_WAKE_NEW: assert property ( // [RL9]
      (q.st == csc_pkg::CSC_SLEEP) && !sleep_i && q.pending && !q.hold && !wr
      |=> (q.cur_src == $past(q.new_src)) && clock_switch_irq_flag_o)
      else $error("wake did not switch to new clock");
   AST_WAKE_OLD: assert property ( // [RL10]
      (q.st == csc_pkg::CSC_SLEEP) && !sleep_i && q.pending && q.hold && !wr
      |=> (q.st == csc_pkg::CSC_WAIT) && q.pending && $stable(q.cur_src))
      else $error("held wake did not re-request");
   AST_READY_BITS: assert property ( // [RL11]
      wb_ack_o && $past(wb_adr_i == csc_pkg::ADR_OSC_STAT && !wb_we_i)
      |-> wb_dat_o[7:2] == $past(osc_ready_i & osc_en_o))
      else $error("ready bits wrong");
   AST_PLL_READY: assert property ( // [RL12]
      rdata[csc_pkg::STAT_PLL_BIT] && (wb_adr_i == csc_pkg::ADR_OSC_STAT)
      |-> pll_lock_i && pll_en_o)
      else $error("pll ready without lock");
   AST_PEND_SET: assert property ( // [RL13]
      wr_new && (wb_dat_i[6:0] != {q.cur_src, q.cur_div}) && (q.st != csc_pkg::CSC_PLL_SWAP)
      |=> q.pending ##1 (q.pending || q.done || (q.st == csc_pkg::CSC_IDLE)))
      else $error("pending not set by new selection");

   COV_SWITCH: cover property (q.pending ##[1:20] !q.pending && q.done);
   COV_PLL_SWAP: cover property (q.st == csc_pkg::CSC_PLL_SWAP ##[1:50] q.st == csc_pkg::CSC_IDLE);
   COV_WAKE: cover property (q.st == csc_pkg::CSC_SLEEP && q.pending ##1 q.st != csc_pkg::CSC_SLEEP);
endmodule : csc_top

// file: tb/tb_top.sv
// clock switch controller: self-checking testbench
`timescale 1ns/1ns
module tb_top;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic ack, pll_lock_i = 1'b1, sleep_i = 1'b0, pll_en, from_ext, suspend, fail, irq, sec;
   logic [5:0] osc_ready_i = 6'h3f, osc_en, tune;
   logic [2:0] src, frq;
   logic [3:0] div;
   logic [7:0] q;
   int failures = 0, num_checks = 0;
   // ---------------------------------------------------------------
   // design under test, short lock timeout
   // ---------------------------------------------------------------
   csc_top #(.LOCK_CYCLES(20)) csc_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .osc_ready_i(osc_ready_i),
      .osc_en_o(osc_en), .pll_lock_i(pll_lock_i), .pll_en_o(pll_en),
      .pll_from_ext_o(from_ext), .sleep_i(sleep_i), .clk_source_o(src),
      .clk_divider_o(div), .clk_suspend_o(suspend), .fail_safe_monitor_fail_o(fail),
      .clock_switch_irq_flag_o(irq), .sec_osc_power_o(sec), .hf_freq_o(frq),
      .hf_tune_o(tune));
   always #4 sys_clk_i = ~sys_clk_i;
   // ---------------------------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------------------------
   // no local limit: only the watchdog may end a wait for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; wdat <= {24'h0, d};
      do begin
         @(posedge sys_clk_i);
      end while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // waits bounded, never a fixed count
   task automatic wait_for(input logic [3:0] which, input int lim);
      int n;
      n = 0;
      while (n < lim && !((which == 4'h8 && suspend === 1'b1) || (which == 4'h9 &&
             fail === 1'b1) || (which < 4'h8 && src === which[2:0]))) begin
         @(posedge sys_clk_i);
         n++;
      end
   endtask : wait_for
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      wb(1'b0, csc_pkg::ADR_OSC_STAT, 8'h00); chk("ready", 8'h40, q);
      wb(1'b1, csc_pkg::ADR_CUR_STAT, 8'hff);
      wb(1'b0, csc_pkg::ADR_CUR_STAT, 8'h00); chk("cur ro", 8'h00, q);
      wb(1'b0, 8'h20, 8'h00); chk("unmapped", 8'h00, q);
      $display("test reset done");
   endtask : t_reset
   task automatic t_div_hold;
      wb(1'b1, csc_pkg::ADR_SW_CTRL, 8'h80);
      wb(1'b1, csc_pkg::ADR_NEW_SEL, 8'h03);
      repeat (8) @(posedge sys_clk_i);
      wb(1'b0, csc_pkg::ADR_SW_CTRL, 8'h00); chk("held ctrl", 8'h88, q);
      wb(1'b0, csc_pkg::ADR_CUR_STAT, 8'h00); chk("held cur", 8'h00, q);
      wb(1'b1, csc_pkg::ADR_SW_CTRL, 8'h00);
      repeat (6) @(posedge sys_clk_i);
      chk("div out", 8'h03, {4'h0, div});
      wb(1'b0, csc_pkg::ADR_SW_CTRL, 8'h00); chk("done ctrl", 8'h10, q);
      chk("irq", 8'h01, {7'h0, irq});
      wb(1'b1, csc_pkg::ADR_EVENT, 8'h03);
      $display("test divider done");
   endtask : t_div_hold
   task automatic t_pll;
      wb(1'b1, csc_pkg::ADR_NEW_SEL, 8'h13);
      wait_for(4'h1, 40);
      chk("src hfpll", 8'h01, {5'h0, src});
      wb(1'b0, csc_pkg::ADR_OSC_STAT, 8'h00); chk("pll rdy", 8'h01, q & 8'h01);
      chk("pll en", 8'h01, {7'h0, pll_en});
      // new input not ready yet: keep running, but enable it
      osc_ready_i <= 6'h1f;
      wb(1'b1, csc_pkg::ADR_NEW_SEL, 8'h23);
      repeat (4) @(posedge sys_clk_i);
      chk("no suspend", 8'h00, {7'h0, suspend});
      chk("new input en", 8'h30, {2'h0, osc_en});
      osc_ready_i <= 6'h3f;
      wait_for(4'h8, 40);
      chk("suspend", 8'h01, {7'h0, suspend});
      pll_lock_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk("old src", 8'h01, {5'h0, src});
      pll_lock_i <= 1'b1;
      wait_for(4'h2, 40);
      @(posedge sys_clk_i);
      chk("pll ext", 8'h03, {6'h0, from_ext, ~suspend});
      $display("test pll done");
   endtask : t_pll
   task automatic t_fail;
      wb(1'b1, csc_pkg::ADR_NEW_SEL, 8'h13);
      wait_for(4'h8, 40);
      pll_lock_i <= 1'b0;
      wait_for(4'h9, 80);
      chk("fail", 8'h01, {7'h0, fail});
      pll_lock_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      chk("kept", 8'h02, {5'h0, src});
      wb(1'b0, csc_pkg::ADR_EVENT, 8'h00); chk("fail evt", 8'h02, q & 8'h02);
      wb(1'b1, csc_pkg::ADR_EVENT, 8'h03);
      $display("test lock fail done");
   endtask : t_fail
   task automatic t_sleep;
      osc_ready_i <= 6'h3b;
      wb(1'b1, csc_pkg::ADR_NEW_SEL, 8'h40);
      // let the request reach the waiting state before sleeping
      @(posedge sys_clk_i);
      sleep_i <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      osc_ready_i <= 6'h3f;
      repeat (4) @(posedge sys_clk_i);
      chk("asleep", 8'h02, {5'h0, src});
      sleep_i <= 1'b0;
      wait_for(4'h4, 20);
      chk("wake new", 8'h09, {4'h0, src, irq});
      wb(1'b1, csc_pkg::ADR_SW_CTRL, 8'h80);
      wb(1'b1, csc_pkg::ADR_NEW_SEL, 8'h50);
      sleep_i <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      sleep_i <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      chk("wake old", 8'h04, {5'h0, src});
      wb(1'b0, csc_pkg::ADR_SW_CTRL, 8'h00); chk("re-req", 8'h88, q);
      wb(1'b1, csc_pkg::ADR_SW_CTRL, 8'h00);
      wait_for(4'h5, 20);
      chk("mf", 8'h05, {5'h0, src});
      $display("test sleep done");
   endtask : t_sleep
   task automatic t_regs;
      wb(1'b1, csc_pkg::ADR_HF_FRQ, 8'h05);
      wb(1'b1, csc_pkg::ADR_HF_TUNE, 8'h2a);
      wb(1'b1, csc_pkg::ADR_OSC_EN, 8'h0c);
      wb(1'b1, csc_pkg::ADR_SW_CTRL, 8'h40);
      wb(1'b0, csc_pkg::ADR_OSC_EN, 8'h00); chk("en reg", 8'h0c, q);
      wb(1'b0, csc_pkg::ADR_OSC_STAT, 8'h00); chk("ready man", 8'h2c, q);
      wb(1'b0, csc_pkg::ADR_SW_CTRL, 8'h00); chk("sec ctrl", 8'h50, q);
      chk("frq out", 8'h05, {5'h0, frq});
      chk("tune out", 8'h2a, {2'h0, tune});
      chk("en out", 8'h0b, {2'h0, osc_en});
      chk("pll off", 8'h00, {7'h0, pll_en});
      chk("sec out", 8'h01, {7'h0, sec});
      $display("test registers done");
   endtask : t_regs
   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_div_hold();
      t_pll();
      t_fail();
      t_sleep();
      t_regs();
      wrap_up();
   end
   // whole run needs well under 2000 cycles
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      failures++;
      wrap_up();
   end
endmodule : tb_top
